// ### tsc_sync_ctrl.sv
// Local design decision: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`include "tsc_cfg.svh"

module tsc_sync_ctrl #(
  parameter int ADDR_W = 8
) (
  input wire logic core_clk_i,
  input wire logic sys_rst_i,
  input wire logic [ADDR_W-1:0] s_axi_awaddr_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  output logic [1:0] s_axi_bresp_o,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  input wire logic [ADDR_W-1:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  input wire logic ext_trigger_in_i,
  input wire logic [2:0] channel_pins_i,
  input wire logic ext_trigger_filtered_i,
  input wire tsc_pkg::tsc_evt_s evt_i,
  output logic sync_trigger_out_o,
  output logic timer_input_one_o,
  output logic ext_trigger_prescaled_o,
  output logic ext_clock_tick_o,
  output logic [3:0] ccx_dma_req_o,
  output logic sync_trigger_event_o,
  output tsc_pkg::tsc_slv_ctrl_s slave_cfg_o,
  output logic irq_o
);

  // ****************************************************************
  // Declarations
  // ****************************************************************
  tsc_pkg::tsc_sync_ctrl_s sync_ctrl_reg;
  tsc_pkg::tsc_slv_ctrl_s slv_ctrl_reg;
  tsc_pkg::tsc_wr_state_e wr_state_reg;
  logic [15:0] irq_sts_reg;
  logic [15:0] irq_sts_next;
  logic [15:0] irq_mask_reg;
  logic aw_held_reg;
  logic w_held_reg;
  logic [ADDR_W-1:0] aw_addr_reg;
  logic [31:0] w_data_reg;
  logic [3:0] w_strb_reg;
  logic wr_fire;
  logic [3:0] pins_sync;
  logic etr_active;
  logic etr_active_d_reg;
  logic [2:0] prediv_cnt_reg;
  logic ext_trigger_filtered_d_reg;
  logic slave_reset_d_reg;
  logic gate_d_reg;
  logic trig_in_d_reg;
  logic sync_trigger_out_next;
  logic clock_mode_on;
  logic ext_tick_next;
  logic [2:0] mode;

  initial
  begin
    if (ADDR_W < 5)
    begin
      $error("tsc_sync_ctrl: ADDR_W must be at least 5");
    end
  end

  function automatic logic reg_hit(input logic [ADDR_W-1:0] addr);
    reg_hit = (addr == ADDR_W'(`TSC_OFS_SYNC_CTRL)) ||
              (addr == ADDR_W'(`TSC_OFS_SLV_CTRL)) ||
              (addr == ADDR_W'(`TSC_OFS_IRQ_STS)) ||
              (addr == ADDR_W'(`TSC_OFS_IRQ_MASK));
  endfunction

  function automatic logic [15:0] merge16(input logic [15:0] old,
                                          input logic [31:0] data,
                                          input logic [3:0] strb,
                                          input logic [15:0] wmask);
    logic [15:0] lanes;
    lanes = {{8{strb[1]}}, {8{strb[0]}}};
    merge16 = (old & ~(lanes & wmask)) | (data[15:0] & lanes & wmask);
  endfunction

  // ****************************************************************
  // AXI4-Lite write channel
  // ****************************************************************
  assign s_axi_awready_o = !aw_held_reg && (wr_state_reg == tsc_pkg::WR_IDLE);
  assign s_axi_wready_o = !w_held_reg && (wr_state_reg == tsc_pkg::WR_IDLE);
  assign wr_fire = aw_held_reg && w_held_reg;
  assign s_axi_bvalid_o = (wr_state_reg == tsc_pkg::WR_RESP);

  always_ff @(posedge core_clk_i)
  begin
    if (sys_rst_i)
    begin
      aw_held_reg <= 1'b0;
      aw_addr_reg <= '0;
    end
    else if (s_axi_awvalid_i && s_axi_awready_o)
    begin
      aw_held_reg <= 1'b1;
      aw_addr_reg <= s_axi_awaddr_i;
    end
    else if (wr_fire)
    begin
      aw_held_reg <= 1'b0;
    end
  end

  always_ff @(posedge core_clk_i)
  begin
    if (sys_rst_i)
    begin
      w_held_reg <= 1'b0;
      w_data_reg <= '0;
      w_strb_reg <= '0;
    end
    else if (s_axi_wvalid_i && s_axi_wready_o)
    begin
      w_held_reg <= 1'b1;
      w_data_reg <= s_axi_wdata_i;
      w_strb_reg <= s_axi_wstrb_i;
    end
    else if (wr_fire)
    begin
      w_held_reg <= 1'b0;
    end
  end

  always_ff @(posedge core_clk_i)
  begin
    if (sys_rst_i)
    begin
      wr_state_reg <= tsc_pkg::WR_IDLE;
      s_axi_bresp_o <= `TSC_RESP_OKAY;
    end
    else
    begin
      case (wr_state_reg)
        tsc_pkg::WR_IDLE:
        begin
          if (wr_fire)
          begin
            wr_state_reg <= tsc_pkg::WR_RESP;
            s_axi_bresp_o <= reg_hit(aw_addr_reg) ? `TSC_RESP_OKAY :
                                                    `TSC_RESP_SLVERR;
          end
        end
        tsc_pkg::WR_RESP:
        begin
          if (s_axi_bready_i)
          begin
            wr_state_reg <= tsc_pkg::WR_IDLE;
          end
        end
        default:
        begin
          wr_state_reg <= tsc_pkg::WR_IDLE;
        end
      endcase
    end
  end

  // ****************************************************************
  // Control registers
  // ****************************************************************
  always_ff @(posedge core_clk_i)
  begin
    if (sys_rst_i)
    begin
      sync_ctrl_reg <= `TSC_RST_SYNC_CTRL;
      slv_ctrl_reg <= `TSC_RST_SLV_CTRL;
      irq_mask_reg <= `TSC_RST_IRQ;
    end
    else if (wr_fire)
    begin
      // Reserved bits stay zero whatever software writes
      if (aw_addr_reg == ADDR_W'(`TSC_OFS_SYNC_CTRL))
      begin
        sync_ctrl_reg <= merge16(sync_ctrl_reg, w_data_reg, w_strb_reg,
                                 `TSC_WMASK_SYNC_CTRL);
      end
      if (aw_addr_reg == ADDR_W'(`TSC_OFS_SLV_CTRL))
      begin
        slv_ctrl_reg <= merge16(slv_ctrl_reg, w_data_reg, w_strb_reg,
                                `TSC_WMASK_SLV_CTRL);
      end
      if (aw_addr_reg == ADDR_W'(`TSC_OFS_IRQ_MASK))
      begin
        irq_mask_reg <= merge16(irq_mask_reg, w_data_reg, w_strb_reg,
                                `TSC_WMASK_IRQ);
      end
    end
  end

  assign slave_cfg_o = slv_ctrl_reg;

  // ****************************************************************
  // Interrupt status, write one to clear, set wins
  // ****************************************************************
  always_comb
  begin
    irq_sts_next = irq_sts_reg;
    if (wr_fire && (aw_addr_reg == ADDR_W'(`TSC_OFS_IRQ_STS)))
    begin
      irq_sts_next = irq_sts_reg & ~merge16(16'h0000, w_data_reg,
                                            w_strb_reg, `TSC_WMASK_IRQ);
    end
    irq_sts_next[`TSC_POS_IRQ_SYNC_TRIGGER_OUT] = irq_sts_next[`TSC_POS_IRQ_SYNC_TRIGGER_OUT] |
      (sync_trigger_out_next && (mode <= `TSC_MM_CMP_PULSE));
    irq_sts_next[`TSC_POS_IRQ_EXTCLK] = irq_sts_next[`TSC_POS_IRQ_EXTCLK] |
                                       ext_tick_next;
  end

  always_ff @(posedge core_clk_i)
  begin
    if (sys_rst_i)
    begin
      irq_sts_reg <= `TSC_RST_IRQ;
      irq_o <= 1'b0;
    end
    else
    begin
      irq_sts_reg <= irq_sts_next;
      irq_o <= |(irq_sts_next & irq_mask_reg);
    end
  end

  // ****************************************************************
  // AXI4-Lite read channel
  // ****************************************************************
  assign s_axi_arready_o = !s_axi_rvalid_o;

  always_ff @(posedge core_clk_i)
  begin
    if (sys_rst_i)
    begin
      s_axi_rvalid_o <= 1'b0;
      s_axi_rdata_o <= '0;
      s_axi_rresp_o <= `TSC_RESP_OKAY;
    end
    else if (s_axi_arvalid_i && s_axi_arready_o)
    begin
      s_axi_rvalid_o <= 1'b1;
      s_axi_rresp_o <= reg_hit(s_axi_araddr_i) ? `TSC_RESP_OKAY :
                                                 `TSC_RESP_SLVERR;
      case (s_axi_araddr_i)
        ADDR_W'(`TSC_OFS_SYNC_CTRL):
          s_axi_rdata_o <= {16'h0000, sync_ctrl_reg};
        ADDR_W'(`TSC_OFS_SLV_CTRL): s_axi_rdata_o <= {16'h0000, slv_ctrl_reg};
        ADDR_W'(`TSC_OFS_IRQ_STS): s_axi_rdata_o <= {16'h0000, irq_sts_reg};
        ADDR_W'(`TSC_OFS_IRQ_MASK): s_axi_rdata_o <= {16'h0000, irq_mask_reg};
        default: s_axi_rdata_o <= '0;
      endcase
    end
    else if (s_axi_rready_i)
    begin
      s_axi_rvalid_o <= 1'b0;
    end
  end

  // ****************************************************************
  // Pin inputs and external trigger conditioning
  // ****************************************************************
  tsc_pin_sync #(
    .WIDTH(4)
  ) tsc_pin_sync_i (
    .core_clk_i(core_clk_i),
    .sys_rst_i(sys_rst_i),
    .pin_i({ext_trigger_in_i, channel_pins_i}),
    .level_o(pins_sync)
  );

  // Reserved source holds the active trigger low whatever the polarity
  assign etr_active = !sync_ctrl_reg.ext_trigger_source_sel &&
                      (pins_sync[3] ^ slv_ctrl_reg.ext_trig_polarity);

  always_ff @(posedge core_clk_i)
  begin
    if (sys_rst_i)
    begin
      timer_input_one_o <= 1'b0;
    end
    else
    begin
      timer_input_one_o <= sync_ctrl_reg.input_one_xor_sel ?
                           ^pins_sync[2:0] : pins_sync[0];
    end
  end

  // Active-edge counter, bit n toggles every 2^n edges
  always_ff @(posedge core_clk_i)
  begin
    if (sys_rst_i)
    begin
      etr_active_d_reg <= 1'b0;
      prediv_cnt_reg <= '0;
      ext_trigger_prescaled_o <= 1'b0;
    end
    else
    begin
      etr_active_d_reg <= etr_active;
      if (etr_active && !etr_active_d_reg)
      begin
        prediv_cnt_reg <= prediv_cnt_reg + 3'h1;
      end
      if (slv_ctrl_reg.ext_trig_prediv == `TSC_PREDIV_OFF)
      begin
        ext_trigger_prescaled_o <= etr_active;
      end
      else
      begin
        ext_trigger_prescaled_o <=
          prediv_cnt_reg[slv_ctrl_reg.ext_trig_prediv - 2'h1];
      end
    end
  end

  // ****************************************************************
  // External clock from filtered trigger
  // ****************************************************************
  // Mode 2, or mode 1 on filtered trigger
  assign clock_mode_on = slv_ctrl_reg.ext_clock2_enable ||
    ((slv_ctrl_reg.slave_mode_sel == `TSC_EXT_CLK1_MODE) &&
     (slv_ctrl_reg.trigger_in_sel == `TSC_TRIGGER_IN_SEL_EXT_TRIGGER_FILTERED));
  assign ext_tick_next = clock_mode_on && ext_trigger_filtered_i &&
                         !ext_trigger_filtered_d_reg;

  always_ff @(posedge core_clk_i)
  begin
    if (sys_rst_i)
    begin
      ext_trigger_filtered_d_reg <= 1'b0;
      ext_clock_tick_o <= 1'b0;
    end
    else
    begin
      ext_trigger_filtered_d_reg <= ext_trigger_filtered_i;
      ext_clock_tick_o <= ext_tick_next;
    end
  end

  // ****************************************************************
  // Sync trigger output, trigger input delay, DMA requests
  // ****************************************************************
  assign mode = sync_ctrl_reg.master_output_sel;

  always_comb
  begin
    case (mode)
      `TSC_MM_RESET: sync_trigger_out_next = evt_i.soft_update_gen ||
                                 slave_reset_d_reg;
      `TSC_MM_ENABLE: sync_trigger_out_next = evt_i.counter_run ||
        (slv_ctrl_reg.master_slave_sync ? evt_i.gate_trigger :
                                          gate_d_reg);
      `TSC_MM_UPDATE: sync_trigger_out_next = evt_i.update_event;
      `TSC_MM_CMP_PULSE: sync_trigger_out_next = evt_i.ch1_match;
      default: sync_trigger_out_next = evt_i.compare_ref[mode[1:0]];
    endcase
  end

  always_ff @(posedge core_clk_i)
  begin
    if (sys_rst_i)
    begin
      slave_reset_d_reg <= 1'b0;
      gate_d_reg <= 1'b0;
      trig_in_d_reg <= 1'b0;
      sync_trigger_out_o <= 1'b0;
      sync_trigger_event_o <= 1'b0;
      ccx_dma_req_o <= '0;
    end
    else
    begin
      slave_reset_d_reg <= evt_i.slave_reset;
      gate_d_reg <= evt_i.gate_trigger;
      trig_in_d_reg <= evt_i.sync_trigger_in;
      // One cycle per event pulse
      sync_trigger_out_o <= sync_trigger_out_next;
      sync_trigger_event_o <= slv_ctrl_reg.master_slave_sync ?
                              trig_in_d_reg : evt_i.sync_trigger_in;
      ccx_dma_req_o <= sync_ctrl_reg.ccx_dma_source_sel ?
                       {4{evt_i.update_event}} : evt_i.cc_event;
    end
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (sys_rst_i);

  update_gen_pulse_a: assert property (
    (mode == `TSC_MM_RESET) && evt_i.soft_update_gen |=> sync_trigger_out_o)
    else $error("update generation gave no sync pulse");
  reset_lag_a: assert property (
    (mode == `TSC_MM_RESET) && evt_i.slave_reset ##1 (mode == `TSC_MM_RESET)
    |=> sync_trigger_out_o)
    else $error("slave reset gave no lagged sync pulse");
  enable_follow_a: assert property (
    (mode == `TSC_MM_ENABLE) && evt_i.counter_run |=> sync_trigger_out_o)
    else $error("sync output not following counter run");
  gate_delay_a: assert property (
    (mode == `TSC_MM_ENABLE) && !slv_ctrl_reg.master_slave_sync &&
    !evt_i.counter_run && !gate_d_reg && evt_i.gate_trigger
    |=> !sync_trigger_out_o)
    else $error("gated enable reached sync output undelayed");
  update_out_a: assert property (
    (mode == `TSC_MM_UPDATE) |=>
    sync_trigger_out_o == $past(evt_i.update_event))
    else $error("update event not on sync output");
  cmp_pulse_a: assert property (
    (mode == `TSC_MM_CMP_PULSE) && evt_i.ch1_match ##1
    ((mode == `TSC_MM_CMP_PULSE) && !evt_i.ch1_match)
    |-> sync_trigger_out_o ##1 !sync_trigger_out_o)
    else $error("compare pulse not exactly one cycle");
  cmp_ref_a: assert property (
    mode[2] |=> sync_trigger_out_o == $past(evt_i.compare_ref[mode[1:0]]))
    else $error("compare reference not on sync output");
  dma_source_a: assert property (
    sync_ctrl_reg.ccx_dma_source_sel && evt_i.update_event
    |=> ccx_dma_req_o == 4'hf)
    else $error("update event gave no DMA requests");
  input_xor_a: assert property (
    sync_ctrl_reg.input_one_xor_sel |=>
    timer_input_one_o == ^$past(pins_sync[2:0]))
    else $error("input one not XOR of channel pins");
  prediv_bypass_a: assert property (
    (slv_ctrl_reg.ext_trig_prediv == `TSC_PREDIV_OFF) |=>
    ext_trigger_prescaled_o == $past(etr_active))
    else $error("prescaler bypass broken");
  ext_clock_a: assert property (
    slv_ctrl_reg.ext_clock2_enable && ext_trigger_filtered_i && !ext_trigger_filtered_d_reg
    |=> ext_clock_tick_o)
    else $error("filtered edge gave no clock tick");
  sync_delay_a: assert property (
    slv_ctrl_reg.master_slave_sync && evt_i.sync_trigger_in
    ##1 slv_ctrl_reg.master_slave_sync |=> sync_trigger_event_o)
    else $error("trigger input event not delayed");
  reserved_zero_a: assert property (
    sync_ctrl_reg.rsvd_hi == 7'h00 && sync_ctrl_reg.rsvd_lo == 3'h0)
    else $error("reserved bits became set");

  update_mode_c: cover property (
    (mode == `TSC_MM_UPDATE) && sync_trigger_out_o);
  ext_tick_c: cover property (clock_mode_on ##[1:20] ext_clock_tick_o);
  irq_raise_c: cover property (!irq_o ##1 irq_o);
  slverr_c: cover property (s_axi_bvalid_o &&
                            s_axi_bresp_o == `TSC_RESP_SLVERR);

endmodule

// ### tsc_cfg.svh
`ifndef TSC_CFG_SVH
`define TSC_CFG_SVH

// ****************************************************************
// Register map
// ****************************************************************
`define TSC_OFS_SYNC_CTRL 8'h04
`define TSC_OFS_SLV_CTRL 8'h08
`define TSC_OFS_IRQ_STS 8'h0c
`define TSC_OFS_IRQ_MASK 8'h10

// ****************************************************************
// Reset values and writable bits
// ****************************************************************
`define TSC_RST_SYNC_CTRL 16'h0000
`define TSC_RST_SLV_CTRL 16'h0000
`define TSC_RST_IRQ 16'h0000
`define TSC_WMASK_SYNC_CTRL 16'h01f8
`define TSC_WMASK_SLV_CTRL 16'hfff7
`define TSC_WMASK_IRQ 16'h0003

// ****************************************************************
// Field positions
// ****************************************************************
`define TSC_POS_SRC_SEL 8
`define TSC_POS_XOR_SEL 7
`define TSC_POS_MASTER_OUTPUT_SEL 4
`define TSC_POS_DMA_SEL 3
`define TSC_POS_POLARITY 15
`define TSC_POS_EC2 14
`define TSC_POS_PREDIV 12
`define TSC_POS_FILTER 8
`define TSC_POS_MSMS 7
`define TSC_POS_TRIGGER_IN_SEL 4
`define TSC_POS_SLAVE_MODE_SEL 0
`define TSC_POS_IRQ_SYNC_TRIGGER_OUT 0
`define TSC_POS_IRQ_EXTCLK 1

// ****************************************************************
// Encodings
// ****************************************************************
`define TSC_MM_RESET 3'h0
`define TSC_MM_ENABLE 3'h1
`define TSC_MM_UPDATE 3'h2
`define TSC_MM_CMP_PULSE 3'h3
`define TSC_EXT_CLK1_MODE 3'h7
`define TSC_TRIGGER_IN_SEL_EXT_TRIGGER_FILTERED 3'h7
`define TSC_PREDIV_OFF 2'h0
`define TSC_RESP_OKAY 2'h0
`define TSC_RESP_SLVERR 2'h2

`endif

// ### tsc_pkg.sv
package tsc_pkg;

  typedef struct packed {
    logic [6:0] rsvd_hi;
    logic ext_trigger_source_sel;
    logic input_one_xor_sel;
    logic [2:0] master_output_sel;
    logic ccx_dma_source_sel;
    logic [2:0] rsvd_lo;
  } tsc_sync_ctrl_s;

  typedef struct packed {
    logic ext_trig_polarity;
    logic ext_clock2_enable;
    logic [1:0] ext_trig_prediv;
    logic [3:0] ext_filter;
    logic master_slave_sync;
    logic [2:0] trigger_in_sel;
    logic rsvd;
    logic [2:0] slave_mode_sel;
  } tsc_slv_ctrl_s;

  typedef struct packed {
    logic soft_update_gen;
    logic slave_reset;
    logic update_event;
    logic ch1_match;
    logic gate_trigger;
    logic counter_run;
    logic sync_trigger_in;
    logic [3:0] cc_event;
    logic [3:0] compare_ref;
  } tsc_evt_s;

  typedef enum logic [1:0] {
    WR_IDLE,
    WR_RESP
  } tsc_wr_state_e;

endpackage

// ### tsc_pin_sync.sv
`timescale 1ns/1ps
`include "tsc_cfg.svh"

// ****************************************************************
// Three-stage pin synchroniser, output moves when stages 2 and 3 agree
// ****************************************************************
module tsc_pin_sync #(
  parameter int WIDTH = 4
) (
  input wire logic core_clk_i,
  input wire logic sys_rst_i,
  input wire logic [WIDTH-1:0] pin_i,
  output logic [WIDTH-1:0] level_o
);

  logic [WIDTH-1:0] stage1_reg;
  logic [WIDTH-1:0] stage2_reg;
  logic [WIDTH-1:0] stage3_reg;

  initial
  begin
    if (WIDTH < 1)
    begin
      $error("tsc_pin_sync: WIDTH must be at least 1");
    end
  end

  always_ff @(posedge core_clk_i)
  begin
    if (sys_rst_i)
    begin
      stage1_reg <= '0;
      stage2_reg <= '0;
      stage3_reg <= '0;
    end
    else
    begin
      stage1_reg <= pin_i;
      stage2_reg <= stage1_reg;
      stage3_reg <= stage2_reg;
    end
  end

  // Each bit follows only once the two late stages agree
  always_ff @(posedge core_clk_i)
  begin
    if (sys_rst_i)
    begin
      level_o <= '0;
    end
    else
    begin
      level_o <= (stage2_reg & stage3_reg) |
                 (level_o & (stage2_reg | stage3_reg));
    end
  end

endmodule

// ### tsc_far_model.sv
`timescale 1ns/1ps
// ****************************************************************
// Far side: slave timer events and external trigger pins
// ****************************************************************
module tsc_far_model (
  input wire logic core_clk_i,
  output tsc_pkg::tsc_evt_s evt_o,
  output logic ext_trigger_in_o,
  output logic [2:0] channel_pins_o,
  output logic ext_trigger_filtered_o
);
  initial
  begin
    evt_o = '0;
    ext_trigger_in_o = 1'b0;
    channel_pins_o = 3'h0;
    ext_trigger_filtered_o = 1'b0;
  end
  // Pin levels change right after an edge
  task automatic pins(input logic e, input logic [2:0] c);
    @(posedge core_clk_i);
    ext_trigger_in_o <= e;
    channel_pins_o <= c;
  endtask
  // Event levels change right after an edge and stand until the next call; the task returns one cycle later
  task automatic level(input tsc_pkg::tsc_evt_s v);
    @(posedge core_clk_i);
    evt_o <= v;
    @(posedge core_clk_i);
  endtask
  task automatic pulse(input tsc_pkg::tsc_evt_s p);
    level(p);
    evt_o <= '0;
  endtask
  // Trigger toggles every 4 cycles, an eighth of the clock rate
  task automatic edges(input int n, input logic filt);
    repeat (2 * n)
    begin
      repeat (4) @(posedge core_clk_i);
      if (filt)
        ext_trigger_filtered_o <= ~ext_trigger_filtered_o;
      else
        ext_trigger_in_o <= ~ext_trigger_in_o;
    end
  endtask
endmodule

// ### timer_trigger_sync_control_bench.sv
`timescale 1ns/1ps
module timer_trigger_sync_control_bench;
  logic clk = 1'b0, rst = 1'b1;
  logic [7:0] awa = 8'h0, ara = 8'h0;
  logic [31:0] wd = 32'h0, rd;
  logic awv = 1'b0, wv = 1'b0, br = 1'b0, arv = 1'b0, rr = 1'b0;
  logic awr, wr, bv, arr, rv, ext_in, filt, pre, tick, so, ti1, ste, irq;
  logic [1:0] bresp, rresp;
  logic [2:0] pins;
  logic [3:0] dma;
  tsc_pkg::tsc_evt_s evt;
  tsc_pkg::tsc_slv_ctrl_s scfg;
  int error_cnt = 0, n_tests = 0, ticks = 0, rises = 0;
  logic pre_d = 1'b0;
  always #12.5 clk = ~clk;
  tsc_sync_ctrl tsc_sync_ctrl_i (.core_clk_i(clk), .sys_rst_i(rst),
    .s_axi_awaddr_i(awa), .s_axi_awvalid_i(awv), .s_axi_awready_o(awr),
    .s_axi_wdata_i(wd), .s_axi_wstrb_i(4'h3), .s_axi_wvalid_i(wv),
    .s_axi_wready_o(wr), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bv),
    .s_axi_bready_i(br), .s_axi_araddr_i(ara), .s_axi_arvalid_i(arv),
    .s_axi_arready_o(arr), .s_axi_rdata_o(rd), .s_axi_rresp_o(rresp),
    .s_axi_rvalid_o(rv), .s_axi_rready_i(rr), .ext_trigger_in_i(ext_in),
    .channel_pins_i(pins), .ext_trigger_filtered_i(filt), .evt_i(evt),
    .sync_trigger_out_o(so), .timer_input_one_o(ti1),
    .ext_trigger_prescaled_o(pre), .ext_clock_tick_o(tick),
    .ccx_dma_req_o(dma), .sync_trigger_event_o(ste),
    .slave_cfg_o(scfg), .irq_o(irq));
  tsc_far_model tsc_far_model_i (.core_clk_i(clk), .evt_o(evt),
    .ext_trigger_in_o(ext_in), .channel_pins_o(pins),
    .ext_trigger_filtered_o(filt));
  always @(posedge clk)
  begin
    if (pre && !pre_d)
      rises++;
    pre_d <= pre;
    if (tick)
      ticks++;
  end
  // ****************************************************************
  // Bus and check helpers
  // ****************************************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic axw(input logic [7:0] a, input logic [15:0] d,
                     input logic [1:0] er);
    @(posedge clk);
    awa <= a;
    wd <= {16'h0, d};
    awv <= 1'b1;
    wv <= 1'b1;
    br <= 1'b1;
    do
    begin
      @(posedge clk);
      if (awv && awr)
        awv <= 1'b0;
      if (wv && wr)
        wv <= 1'b0;
    end while (!bv);
    br <= 1'b0;
    chk(bresp, er);
  endtask
  task automatic axr(input logic [7:0] a, input logic [15:0] ed,
                     input logic [1:0] er);
    @(posedge clk);
    ara <= a;
    arv <= 1'b1;
    rr <= 1'b1;
    do
    begin
      @(posedge clk);
      if (arv && arr)
        arv <= 1'b0;
    end while (!rv);
    rr <= 1'b0;
    chk(rd, {16'h0, ed});
    chk(rresp, er);
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask
  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_regs();
    axr(8'h04, 16'h0000, 2'h0);
    axr(8'h08, 16'h0000, 2'h0);
    axw(8'h04, 16'h01f8, 2'h0);
    axr(8'h04, 16'h01f8, 2'h0);
    axw(8'h08, 16'hfff7, 2'h0);
    axr(8'h08, 16'hfff7, 2'h0);
    chk(scfg, 16'hfff7);
    axw(8'h08, 16'h0000, 2'h0);
    axw(8'h14, 16'h0001, 2'h2);
    axr(8'h14, 16'h0000, 2'h2);
  endtask
  task automatic t_modes();
    tsc_pkg::tsc_evt_s su, c;
    su = '0;
    su.soft_update_gen = 1'b1;
    for (int m = 2; m < 8; m++)
    begin
      c = '0;
      if (m == 2)
        c.update_event = 1'b1;
      else if (m == 3)
        c.ch1_match = 1'b1;
      else
        c.compare_ref[m - 4] = 1'b1;
      axw(8'h04, 16'(m << 4), 2'h0);
      tsc_far_model_i.pulse(su);
      settle(0);
      chk(so, 0);
      tsc_far_model_i.pulse(c);
      settle(0);
      chk(so, 1);
      settle(0);
      chk(so, 0);
    end
    axw(8'h04, 16'h0000, 2'h0);
    tsc_far_model_i.pulse(su);
    settle(0);
    chk(so, 1);
    settle(0);
    chk(so, 0);
    c = '0;
    c.slave_reset = 1'b1;
    tsc_far_model_i.pulse(c);
    settle(0);
    chk(so, 0);
    settle(0);
    chk(so, 1);
    settle(0);
    chk(so, 0);
    axw(8'h04, 16'h0010, 2'h0);
    c = '0;
    c.counter_run = 1'b1;
    tsc_far_model_i.pulse(c);
    settle(0);
    chk(so, 1);
    c = '0;
    c.gate_trigger = 1'b1;
    tsc_far_model_i.level(c);
    settle(0);
    chk(so, 0);
    settle(0);
    chk(so, 1);
    tsc_far_model_i.level('0);
    axw(8'h08, 16'h0080, 2'h0);
    tsc_far_model_i.pulse(c);
    settle(0);
    chk(so, 1);
    c = '0;
    c.sync_trigger_in = 1'b1;
    tsc_far_model_i.pulse(c);
    settle(0);
    chk(ste, 0);
    settle(0);
    chk(ste, 1);
    axw(8'h08, 16'h0000, 2'h0);
    tsc_far_model_i.pulse(c);
    settle(0);
    chk(ste, 1);
  endtask
  task automatic t_dma();
    tsc_pkg::tsc_evt_s c;
    c = '0;
    c.cc_event = 4'h5;
    axw(8'h04, 16'h0000, 2'h0);
    tsc_far_model_i.pulse(c);
    settle(0);
    chk(dma, 4'h5);
    axw(8'h04, 16'h0008, 2'h0);
    c.cc_event = 4'hf;
    tsc_far_model_i.pulse(c);
    settle(0);
    chk(dma, 4'h0);
    c = '0;
    c.update_event = 1'b1;
    tsc_far_model_i.pulse(c);
    settle(0);
    chk(dma, 4'hf);
  endtask
  task automatic t_pins();
    tsc_far_model_i.pins(1'b0, 3'b011);
    axw(8'h04, 16'h0000, 2'h0);
    settle(8);
    chk(ti1, 1);
    axw(8'h04, 16'h0080, 2'h0);
    settle(8);
    chk(ti1, 0);
    tsc_far_model_i.pins(1'b1, 3'b011);
    axw(8'h04, 16'h0000, 2'h0);
    settle(8);
    chk(pre, 1);
    axw(8'h08, 16'h8000, 2'h0);
    settle(8);
    chk(pre, 0);
    axw(8'h08, 16'h0000, 2'h0);
    axw(8'h04, 16'h0100, 2'h0);
    settle(8);
    chk(pre, 0);
    tsc_far_model_i.pins(1'b0, 3'b011);
    axw(8'h04, 16'h0000, 2'h0);
    for (int p = 0; p < 4; p++)
    begin
      axw(8'h08, 16'(p << 12), 2'h0);
      settle(8);
      rises = 0;
      tsc_far_model_i.edges(8, 1'b0);
      settle(8);
      chk(rises, 8 >> p);
    end
  endtask
  task automatic t_clk();
    logic [15:0] cfg [4] = '{16'h0000, 16'h4000, 16'h0077, 16'h4077};
    axw(8'h08, 16'h0000, 2'h0);
    axw(8'h0c, 16'h0003, 2'h0);
    axw(8'h10, 16'h0002, 2'h0);
    for (int k = 0; k < 4; k++)
    begin
      axw(8'h08, cfg[k], 2'h0);
      settle(0);
      ticks = 0;
      tsc_far_model_i.edges(3, 1'b1);
      settle(4);
      chk(ticks, (k == 0) ? 0 : 3);
      chk(irq, k != 0);
    end
    axr(8'h0c, 16'h0002, 2'h0);
    axw(8'h10, 16'h0000, 2'h0);
    settle(2);
    chk(irq, 0);
    axw(8'h10, 16'h0002, 2'h0);
    settle(2);
    chk(irq, 1);
    axw(8'h0c, 16'h0002, 2'h0);
    settle(2);
    chk(irq, 0);
    axr(8'h0c, 16'h0000, 2'h0);
  endtask
  task automatic results();
    $display("tests %0d errors %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  initial
  begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    results();
  end
  initial
  begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    t_regs();
    t_modes();
    t_dma();
    t_pins();
    t_clk();
    results();
  end
endmodule
